// ==== rtl/sdad_top.sv ====
// Alarm detector with register port, alarm code hold and interrupt.
//
// Function
// - Raise alarm 93.0 when the gear ratio is outside 1/1000..1000.
// - Raise alarm 93.2 when the encoder ratio is outside 1/40..160.
// - Raise alarm 93.3 when the feedback type differs from the one seen.
// - Raise alarm 95.x (sub 0 to 4) when the motor does not fit the drive.
// - Raise alarm 99.0 when a safety input rises in a clear begun unsafe.
// - Raise alarm 30.0 while at least one of the two safety inputs is off.
// - Raise alarm 99.0 when a spurious internal error signal is seen.
// - Raise a 99 group alarm when self diagnosis reports an internal fault.
`timescale 1ns/1ps
module sdad_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Drive status inputs
    input  wire logic [3:0]  detected_encoder_type,
    input  wire logic        motor_mismatch,
    input  wire logic [2:0]  motor_mismatch_sub,
    input  wire logic        safety_in1_on,
    input  wire logic        safety_in2_on,
    input  wire logic        noise_error,
    input  wire logic        self_diag_fault,
    // Alarm outputs
    output logic      [7:0]  alarm_main,
    output logic      [3:0]  alarm_sub,
    output logic             alarm_active,
    output logic             irq
);
    typedef struct packed {
        logic [31:0]            gear;
        logic [31:0]            ext_ratio;
        logic [3:0]             fb_type;
        logic [7:0]             a_main;
        logic [3:0]             a_sub;
        logic                   a_act;
        logic [sdad_pkg::EV_W-1:0] status;
        logic [sdad_pkg::EV_W-1:0] mask;
        sdad_pkg::sdad_clr_e    clr;
        logic [7:0]             clr_cnt;
        logic                   clr_safe_off;
        logic                   saf_prev;
        logic [31:0]            rdata;
    } sdad_state_s;

    sdad_state_s st_reg;
    sdad_state_s st_next;

    // True when num/den lies outside lo..hi, with lo as 1/lo_den.
    function automatic logic ratio_bad(input logic [31:0] r,
                                       input logic [15:0] hi,
                                       input logic [15:0] lo_den);
        logic [31:0] num_hi;
        logic [31:0] den_hi;
        num_hi = 32'(r[31:16]);
        den_hi = 32'(r[15:0]);
        ratio_bad = (r[15:0] == 16'h0000) || (r[31:16] == 16'h0000)
                 || (num_hi > den_hi * 32'(hi))
                 || (den_hi > num_hi * 32'(lo_den));
    endfunction : ratio_bad

    logic safe_all;
    logic gear_bad;
    logic ext_bad;
    logic conn_bad;
    logic win_rise;
    logic [sdad_pkg::EV_W-1:0] ev;
    logic [7:0] new_main;
    logic [3:0] new_sub;
    logic       new_hit;
    logic       clr_req;

    assign safe_all = safety_in1_on & safety_in2_on;
    assign gear_bad = ratio_bad(st_reg.gear, sdad_pkg::GEAR_LIMIT,
                                sdad_pkg::GEAR_LIMIT);
    assign ext_bad  = ratio_bad(st_reg.ext_ratio, sdad_pkg::EXT_HI,
                                sdad_pkg::EXT_LO_DEN);
    assign conn_bad = st_reg.fb_type != detected_encoder_type;
    assign clr_req  = reg_wr && reg_addr == sdad_pkg::ADR_CLEAR;
    // A rise of either input while a clear begun unsafe is in progress.
    assign win_rise = st_reg.clr == sdad_pkg::SDAD_CLEARING
                   && st_reg.clr_safe_off
                   && (safe_all || ({safety_in1_on, safety_in2_on} != 2'b00
                       && !st_reg.saf_prev));

    // Events: 0 param, 1 motor, 2 safety, 3 other 99, 4 clear timing.
    assign ev = {win_rise, noise_error | self_diag_fault, !safe_all,
                 motor_mismatch, gear_bad | ext_bad | conn_bad};

    // Priority: 99 group first, then motor, parameter, safety.
    always_comb
    begin
        new_hit  = 1'b1;
        new_main = sdad_pkg::MAIN_OTHER;
        new_sub  = sdad_pkg::SUB_ZERO;
        if (win_rise || noise_error)
        begin
            new_sub = sdad_pkg::SUB_ZERO;
        end
        else if (self_diag_fault)
        begin
            new_sub = sdad_pkg::SUB_SELF_DIAG;
        end
        else if (motor_mismatch)
        begin
            new_main = sdad_pkg::MAIN_MOTOR;
            new_sub  = (4'(motor_mismatch_sub) > sdad_pkg::SUB_MOTOR_MAX)
                     ? sdad_pkg::SUB_MOTOR_MAX : 4'(motor_mismatch_sub);
        end
        else if (gear_bad)
        begin
            new_main = sdad_pkg::MAIN_PARAM;
            new_sub  = sdad_pkg::SUB_GEAR;
        end
        else if (ext_bad)
        begin
            new_main = sdad_pkg::MAIN_PARAM;
            new_sub  = sdad_pkg::SUB_EXT_RATIO;
        end
        else if (conn_bad)
        begin
            new_main = sdad_pkg::MAIN_PARAM;
            new_sub  = sdad_pkg::SUB_EXT_CONN;
        end
        else if (!safe_all)
        begin
            new_main = sdad_pkg::MAIN_SAFETY;
            new_sub  = sdad_pkg::SUB_ZERO;
        end
        else
        begin
            new_hit = 1'b0;
        end
    end

    always_comb
    begin
        st_next          = st_reg;
        st_next.saf_prev = {safety_in1_on, safety_in2_on} != 2'b00
                           && !safe_all ? 1'b1 : safe_all;
        st_next.rdata    = 32'h0;
        if (reg_wr)
        begin
            case (reg_addr)
                sdad_pkg::ADR_GEAR:      st_next.gear = reg_wdata;
                sdad_pkg::ADR_EXT_RATIO: st_next.ext_ratio = reg_wdata;
                sdad_pkg::ADR_FB_TYPE:   st_next.fb_type = reg_wdata[3:0];
                sdad_pkg::ADR_MASK:
                    st_next.mask = reg_wdata[sdad_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                sdad_pkg::ADR_GEAR:      st_next.rdata = st_reg.gear;
                sdad_pkg::ADR_EXT_RATIO: st_next.rdata = st_reg.ext_ratio;
                sdad_pkg::ADR_FB_TYPE:   st_next.rdata = 32'(st_reg.fb_type);
                sdad_pkg::ADR_ALARM:
                    st_next.rdata = 32'({st_reg.a_act, 3'h0,
                                         st_reg.a_main, st_reg.a_sub});
                sdad_pkg::ADR_STATUS:    st_next.rdata = 32'(st_reg.status);
                sdad_pkg::ADR_MASK:      st_next.rdata = 32'(st_reg.mask);
                default:                 st_next.rdata = 32'h0;
            endcase
        end
        // Read clears status, but an event in the same cycle wins.
        if (reg_rd && reg_addr == sdad_pkg::ADR_STATUS)
        begin
            st_next.status = ev;
        end
        else
        begin
            st_next.status = st_reg.status | ev;
        end
        // Clear process: it runs a fixed window watching the safety inputs.
        case (st_reg.clr)
            sdad_pkg::SDAD_IDLE:
            begin
                if (clr_req)
                begin
                    st_next.a_act        = 1'b0;
                    st_next.a_main       = 8'h0;
                    st_next.a_sub        = 4'h0;
                    st_next.clr          = sdad_pkg::SDAD_CLEARING;
                    st_next.clr_cnt      = sdad_pkg::CLR_WIN_CYC;
                    st_next.clr_safe_off = !safe_all;
                end
            end
            sdad_pkg::SDAD_CLEARING:
            begin
                st_next.clr_cnt = st_reg.clr_cnt - 8'h01;
                if (st_reg.clr_cnt == 8'h01)
                begin
                    st_next.clr = sdad_pkg::SDAD_IDLE;
                end
            end
            default: st_next.clr = sdad_pkg::SDAD_IDLE;
        endcase
        // The first alarm is latched; later ones wait until a clear, except a clear timing rise, which overwrites it with 99.0.
        if (new_hit && !st_reg.a_act && !clr_req)
        begin
            st_next.a_act  = 1'b1;
            st_next.a_main = new_main;
            st_next.a_sub  = new_sub;
        end
        else if (win_rise)
        begin
            st_next.a_act  = 1'b1;
            st_next.a_main = sdad_pkg::MAIN_OTHER;
            st_next.a_sub  = sdad_pkg::SUB_ZERO;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_reg           <= '0;
            st_reg.gear      <= 32'h0001_0001;
            st_reg.ext_ratio <= 32'h0001_0001;
            st_reg.clr       <= sdad_pkg::SDAD_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata    = st_reg.rdata;
    assign alarm_main   = st_reg.a_main;
    assign alarm_sub    = st_reg.a_sub;
    assign alarm_active = st_reg.a_act;
    assign irq          = |(st_reg.status & st_reg.mask);

    a_safety_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        !safe_all && !st_reg.a_act && !clr_req && !win_rise
        && !noise_error && !self_diag_fault && !motor_mismatch
        && !gear_bad && !ext_bad && !conn_bad
        |=> alarm_active && alarm_main == sdad_pkg::MAIN_SAFETY)
        else $error("safety alarm not raised");
    a_noise_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        noise_error && !st_reg.a_act && !clr_req
        |=> alarm_main == sdad_pkg::MAIN_OTHER && alarm_sub == 4'h0)
        else $error("noise alarm not raised");
    a_diag_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        self_diag_fault && !noise_error && !st_reg.a_act && !clr_req
        |=> alarm_main == sdad_pkg::MAIN_OTHER)
        else $error("self diagnosis alarm missing");
    a_motor_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        motor_mismatch && !noise_error && !self_diag_fault && !win_rise
        && !st_reg.a_act && !clr_req
        |=> alarm_main == sdad_pkg::MAIN_MOTOR && alarm_sub <= 4'h4)
        else $error("motor alarm wrong");
    a_gear_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        gear_bad && !motor_mismatch && !noise_error && !self_diag_fault
        && !win_rise && !st_reg.a_act && !clr_req
        |=> alarm_main == sdad_pkg::MAIN_PARAM && alarm_sub == 4'h0)
        else $error("gear alarm wrong");
    a_ext_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        ext_bad && !gear_bad && !motor_mismatch && !noise_error
        && !self_diag_fault && !win_rise && !st_reg.a_act && !clr_req
        |=> alarm_sub == 4'h2)
        else $error("external ratio alarm wrong");
    a_conn_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        conn_bad && !ext_bad && !gear_bad && !motor_mismatch && !noise_error
        && !self_diag_fault && !win_rise && !st_reg.a_act && !clr_req
        |=> alarm_sub == 4'h3)
        else $error("connection alarm wrong");
    a_clear_window: assert property (@(posedge sys_clk) disable iff (srst)
        win_rise |=> alarm_active && alarm_main == sdad_pkg::MAIN_OTHER)
        else $error("clear timing alarm missing");
    a_alarm_hold: assert property (@(posedge sys_clk) disable iff (srst)
        alarm_active && !clr_req && !win_rise
        |=> alarm_active && $stable(alarm_main))
        else $error("held alarm changed");

    // A clear taken while idle always drops the code for one cycle, even
    // with a fault still present, so the host can see that it landed.
    a_clear_drops: assert property (@(posedge sys_clk) disable iff (srst)
        clr_req && st_reg.clr == sdad_pkg::SDAD_IDLE
        |=> !alarm_active)
        else $error("clear did not drop the alarm");

    // Status bits are sticky; a read in the same cycle must not lose an
    // event, otherwise a short fault could vanish between two polls.
    a_safety_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        !safe_all
        |=> st_reg.status[2])
        else $error("safety status bit lost");

    // Noise and self diagnosis share one status bit.
    a_noise_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        noise_error
        |=> st_reg.status[3])
        else $error("noise status bit lost");

    // Self diagnosis must be told apart from noise by its sub code.
    a_diag_sub: assert property (@(posedge sys_clk) disable iff (srst)
        self_diag_fault && !noise_error && !win_rise
        && !st_reg.a_act && !clr_req
        |=> alarm_sub == sdad_pkg::SUB_SELF_DIAG)
        else $error("self diagnosis sub code wrong");

    // The clear window is bounded; a stuck window would block later clears.
    a_window_end: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.clr == sdad_pkg::SDAD_CLEARING && st_reg.clr_cnt == 8'h01
        |=> st_reg.clr == sdad_pkg::SDAD_IDLE)
        else $error("clear window did not end");

    // Read data stand only in the cycle after a read strobe.
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (srst)
        !reg_rd
        |=> reg_rdata == 32'h0)
        else $error("read data outside a read");

    // The alarm register shows the held pair as it stood when read.
    a_alarm_read: assert property (@(posedge sys_clk) disable iff (srst)
        reg_rd && reg_addr == sdad_pkg::ADR_ALARM
        |=> reg_rdata[11:4] == $past(alarm_main)
            && reg_rdata[3:0] == $past(alarm_sub))
        else $error("alarm register read wrong");

    c_clear: cover property (@(posedge sys_clk) disable iff (srst)
        clr_req ##1 st_reg.clr == sdad_pkg::SDAD_CLEARING);
    c_window: cover property (@(posedge sys_clk) disable iff (srst)
        win_rise);
    c_irq: cover property (@(posedge sys_clk) disable iff (srst) irq);
    // Motor and self diagnosis alarms are the least common paths.
    c_motor: cover property (@(posedge sys_clk) disable iff (srst)
        alarm_main == sdad_pkg::MAIN_MOTOR);
    c_diag: cover property (@(posedge sys_clk) disable iff (srst)
        alarm_sub == sdad_pkg::SUB_SELF_DIAG);
endmodule : sdad_top

// ==== rtl/sdad_pkg.sv ====
// Constants and types shared by the servo drive alarm detector.
package sdad_pkg;
    localparam int unsigned RATIO_W       = 16;
    // Alarm main and sub codes, plain binary values of the figures as displayed.
    localparam logic [7:0] MAIN_PARAM     = 8'd93;
    localparam logic [7:0] MAIN_MOTOR     = 8'd95;
    localparam logic [7:0] MAIN_OTHER     = 8'd99;
    localparam logic [7:0] MAIN_SAFETY    = 8'd30;
    localparam logic [3:0] SUB_GEAR       = 4'h0;
    localparam logic [3:0] SUB_EXT_RATIO  = 4'h2;
    localparam logic [3:0] SUB_EXT_CONN   = 4'h3;
    localparam logic [3:0] SUB_ZERO       = 4'h0;
    localparam logic [3:0] SUB_MOTOR_MAX  = 4'h4;
    localparam logic [3:0] SUB_SELF_DIAG  = 4'h1;
    // Ratio limits, checked by comparing each half with the other half times a bound.
    localparam logic [15:0] GEAR_LIMIT    = 16'd1000;
    localparam logic [15:0] EXT_HI        = 16'd160;
    localparam logic [15:0] EXT_LO_DEN    = 16'd40;
    // Window of the clear process in which a safety rise is fatal.
    localparam logic [7:0] CLR_WIN_CYC    = 8'h10;
    // Register map of the plain register port.
    localparam logic [3:0] ADR_GEAR       = 4'h0;
    localparam logic [3:0] ADR_EXT_RATIO  = 4'h1;
    localparam logic [3:0] ADR_FB_TYPE    = 4'h2;
    localparam logic [3:0] ADR_ALARM      = 4'h3;
    localparam logic [3:0] ADR_STATUS     = 4'h4;
    localparam logic [3:0] ADR_MASK       = 4'h5;
    localparam logic [3:0] ADR_CLEAR      = 4'h6;
    localparam int unsigned EV_W          = 5;
    typedef enum logic [1:0] {SDAD_IDLE, SDAD_CLEARING} sdad_clr_e;
endpackage : sdad_pkg

// ==== tb/sdad_host.sv ====
// Host controller model that reaches the alarm registers.
`timescale 1ns/1ps
module sdad_host (
    // Clock
    input  wire logic        sys_clk,
    // Register port
    output logic      [3:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    initial
    begin
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe, so sample just past it.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : sdad_host

// ==== tb/test_sdad_top.sv ====
// Self-checking bench for the servo drive alarm detector.
`timescale 1ns/1ps
module test_sdad_top;
    logic        sys_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [3:0]  detected_encoder_type = 4'h0;
    logic        motor_mismatch        = 1'b0;
    logic [2:0]  motor_mismatch_sub    = 3'h0;
    logic        safety_in1_on         = 1'b1;
    logic        safety_in2_on         = 1'b1;
    logic        noise_error           = 1'b0;
    logic        self_diag_fault       = 1'b0;
    logic [7:0]  alarm_main;
    logic [3:0]  alarm_sub;
    logic        alarm_active;
    logic        irq;
    logic [31:0] rv;
    int          bad_count    = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    sdad_top sdad_top_i (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .detected_encoder_type(detected_encoder_type),
        .motor_mismatch(motor_mismatch),
        .motor_mismatch_sub(motor_mismatch_sub),
        .safety_in1_on(safety_in1_on), .safety_in2_on(safety_in2_on),
        .noise_error(noise_error), .self_diag_fault(self_diag_fault),
        .alarm_main(alarm_main), .alarm_sub(alarm_sub),
        .alarm_active(alarm_active), .irq(irq));

    sdad_host sdad_host_i (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    always #10 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // A hung handshake would otherwise stall the run forever.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic check(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // A zero main code means that no alarm may be held.
    task automatic alarm(input logic [7:0] m, input logic [3:0] s);
        cyc(3);
        #1;
        check("alarm_active", {31'h0, alarm_active}, {31'h0, m != 8'h0});
        if (m != 8'h0)
        begin
            check("alarm_main", {24'h0, alarm_main}, {24'h0, m});
            check("alarm_sub", {28'h0, alarm_sub}, {28'h0, s});
        end
    endtask : alarm

    // The clear is only issued with both safety inputs on.
    task automatic clear();
        sdad_host_i.wr(sdad_pkg::ADR_CLEAR, 32'h0);
        cyc(20);
    endtask : clear

    task automatic t_gear();
        sdad_host_i.wr(sdad_pkg::ADR_GEAR, 32'h03e8_0001);
        alarm(8'h0, 4'h0);
        sdad_host_i.wr(sdad_pkg::ADR_GEAR, 32'h0001_03e8);
        alarm(8'h0, 4'h0);
        sdad_host_i.wr(sdad_pkg::ADR_GEAR, 32'h03e9_0001);
        alarm(sdad_pkg::MAIN_PARAM, sdad_pkg::SUB_GEAR);
        sdad_host_i.rd(sdad_pkg::ADR_ALARM, rv);
        check("alarm_reg", rv, {16'h0, 4'h8, sdad_pkg::MAIN_PARAM,
            sdad_pkg::SUB_GEAR});
        sdad_host_i.wr(sdad_pkg::ADR_GEAR, 32'h0001_0001);
        alarm(sdad_pkg::MAIN_PARAM, sdad_pkg::SUB_GEAR);
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_gear

    task automatic t_ext();
        sdad_host_i.wr(sdad_pkg::ADR_EXT_RATIO, 32'h00a0_0001);
        alarm(8'h0, 4'h0);
        sdad_host_i.wr(sdad_pkg::ADR_EXT_RATIO, 32'h0001_0029);
        alarm(sdad_pkg::MAIN_PARAM, sdad_pkg::SUB_EXT_RATIO);
        sdad_host_i.wr(sdad_pkg::ADR_EXT_RATIO, 32'h0001_0001);
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_ext

    task automatic t_fb();
        sdad_host_i.wr(sdad_pkg::ADR_FB_TYPE, 32'h5);
        alarm(sdad_pkg::MAIN_PARAM, sdad_pkg::SUB_EXT_CONN);
        detected_encoder_type <= 4'h5;
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_fb

    task automatic t_motor();
        motor_mismatch     <= 1'b1;
        motor_mismatch_sub <= 3'h2;
        alarm(sdad_pkg::MAIN_MOTOR, 4'h2);
        motor_mismatch <= 1'b0;
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_motor

    task automatic t_safety_irq();
        sdad_host_i.rd(sdad_pkg::ADR_STATUS, rv);
        sdad_host_i.wr(sdad_pkg::ADR_MASK, 32'h4);
        safety_in2_on <= 1'b0;
        alarm(sdad_pkg::MAIN_SAFETY, sdad_pkg::SUB_ZERO);
        check("irq", {31'h0, irq}, 32'h1);
        safety_in2_on <= 1'b1;
        cyc(2);
        sdad_host_i.rd(sdad_pkg::ADR_STATUS, rv);
        check("status", rv, 32'h4);
        cyc(1);
        #1;
        check("irq", {31'h0, irq}, 32'h0);
        sdad_host_i.rd(4'hf, rv);
        check("unmapped", rv, 32'h0);
        sdad_host_i.wr(sdad_pkg::ADR_MASK, 32'h0);
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_safety_irq

    task automatic t_window();
        safety_in1_on <= 1'b0;
        cyc(3);
        sdad_host_i.wr(sdad_pkg::ADR_CLEAR, 32'h0);
        cyc(2);
        safety_in1_on <= 1'b1;
        alarm(sdad_pkg::MAIN_OTHER, sdad_pkg::SUB_ZERO);
        // A clear inside the running window is ignored, so let it end.
        cyc(16);
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_window

    task automatic t_internal();
        noise_error <= 1'b1;
        cyc(1);
        noise_error <= 1'b0;
        alarm(sdad_pkg::MAIN_OTHER, sdad_pkg::SUB_ZERO);
        clear();
        self_diag_fault <= 1'b1;
        cyc(1);
        self_diag_fault <= 1'b0;
        alarm(sdad_pkg::MAIN_OTHER, sdad_pkg::SUB_SELF_DIAG);
        clear();
        alarm(8'h0, 4'h0);
    endtask : t_internal

    initial
    begin
        cyc(6);
        srst <= 1'b0;
        cyc(1);
        alarm(8'h0, 4'h0);
        t_gear();
        t_ext();
        t_fb();
        t_motor();
        t_safety_irq();
        t_window();
        t_internal();
        give_verdict();
    end
endmodule : test_sdad_top
